// ===== watchdog_temp_monitor_port.sv
// watchdog output gating and temperature monitor behind a host i/o window
// What this block does
// (RULE1) host software initialises timer and watchdog first
// (RULE2) watchdog outputs held inactive until software release
// (RULE3) host write starts conversion; busy flag polled
// (RULE4) auto mode repeats conversions every 1 or 4s
// (RULE5) result reaching limit raises over-limit interrupt line
// (RULE6) over-limit condition readable as status bit
// (RULE7) expiry drives ttl, open-collector and relay together
// (RULE8) only i/o read/write cycles answered, memory ignored
// (RULE9) window spans eight contiguous byte addresses
// (RULE10) all sixteen address lines compared
// (RULE11) base from eight switches, 8-byte steps, below 0800h
// (RULE12) claimed accesses finish with no wait states
// (RULE13) 8-bit result against 8-bit limit per conversion
module watchdog_temp_monitor_port
    import wdt_mon_pkg::*;
(
    input  wire logic                 clk_in,
    input  wire logic                 resetn_in,
    input  wire logic [15:0]          io_addr_in,       // host address lines
    input  wire logic                 io_rd_in,         // one-cycle i/o read strobe
    input  wire logic                 io_wr_in,         // one-cycle i/o write strobe
    input  wire logic                 mem_cycle_in,     // high for memory cycles
    input  wire logic [7:0]           io_wdata_in,      // host write data
    input  wire logic [BASE_SW_W-1:0] base_sw_in,       // base address switches
    input  wire logic                 long_interval_in, // 1: 4 s repeat, 0: 1 s
    input  wire logic                 adc_done_in,      // converter finished pulse
    input  wire logic [7:0]           adc_result_in,    // converter result
    input  wire logic                 dog_expired_in,   // watchdog timer has run down
    output logic                      adc_start_out,    // one-cycle start to converter
    output logic [7:0]                io_rdata_out,     // read data
    output logic                      io_claim_out,     // window hit, no wait states
    output logic                      over_limit_irq_line_out,
    output logic                      dog_ttl_out,      // buffered timeout level
    output logic                      dog_oc_oe_out,    // open-collector pull-down enable
    output logic                      dog_relay_out     // relay coil drive
);

    // whole register state
    typedef struct packed {
        conv_state_e       conv;
        logic              auto_mode;
        logic              auto_armed;
        logic [TICK_W-1:0] tick;
        logic [7:0]        limit;
        logic [7:0]        result;
        logic              over_limit_flag;
        logic              irq;
        logic              dog_released;
        logic              start;
        logic [7:0]        rdata;
        logic              claim;
        logic              ttl;
        logic              oc;
        logic              relay;
    } state_s;

    state_s state_reg;  // registered state
    state_s state_next; // next state

    // window hit: all sixteen lines, base in 8-byte steps
    function automatic logic window_hit(input logic [15:0] a, input logic [BASE_SW_W-1:0] sw);
        window_hit = (a[15:OFS_W] == {5'h00, sw}); // RULE10 RULE11 RULE9
    endfunction : window_hit

    logic              hit;      // decoded window hit
    logic              acc_rd;   // claimed read
    logic              acc_wr;   // claimed write
    logic [OFS_W-1:0]  ofs;      // offset inside window
    logic [TICK_W-1:0] period;   // selected repeat interval in cycles

    // next-state logic
    always_comb begin
        state_next = state_reg;
        hit    = window_hit(io_addr_in, base_sw_in);
        acc_rd = hit && io_rd_in && !mem_cycle_in;  // RULE8
        acc_wr = hit && io_wr_in && !mem_cycle_in;  // RULE8
        ofs    = io_addr_in[OFS_W-1:0];
        period = long_interval_in ? TICK_W'(TICKS_LONG) : TICK_W'(TICKS_SHORT); // RULE4
        state_next.start = 1'b0;
        state_next.claim = acc_rd || acc_wr; // RULE12
        // read data is registered the same cycle, ready next edge, no wait
        state_next.rdata = BYTE_ZERO;
        if (acc_rd) begin
            case (ofs)
                OFS_ADC_DATA: begin
                    state_next.rdata = state_reg.result;
                end
                OFS_ADC_STATUS: begin
                    // busy reads 1, dog 1 = not expired, over-limit 1 = limit reached
                    state_next.rdata[ST_EOC_BIT]  = (state_reg.conv == CONV_BUSY); // RULE3
                    state_next.rdata[ST_DOG_BIT]  = !dog_expired_in;
                    state_next.rdata[ST_OVER_BIT] = state_reg.over_limit_flag; // RULE6
                    state_next.irq = 1'b0; // status read clears the request
                end
                OFS_LIMIT: begin
                    state_next.rdata = state_reg.limit;
                end
                default: begin
                    state_next.rdata = BYTE_ZERO; // unused offsets read zero
                end
            endcase
        end
        // host writes
        if (acc_wr) begin
            case (ofs)
                OFS_CONV_START: begin
                    state_next.start      = 1'b1; // RULE3
                    state_next.conv       = CONV_BUSY;
                    state_next.auto_armed = state_reg.auto_mode; // first auto start
                    state_next.tick       = '0;
                end
                OFS_LIMIT: begin
                    state_next.limit = io_wdata_in;
                end
                OFS_MODE: begin
                    state_next.auto_mode = io_wdata_in[MODE_AUTO_BIT]; // RULE4
                    state_next.irq       = 1'b0; // mode write clears the request
                    if (!io_wdata_in[MODE_AUTO_BIT]) begin
                        state_next.auto_armed = 1'b0;
                    end
                end
                OFS_DOG: begin
                    // release bit must be refreshed on every trigger
                    state_next.dog_released = io_wdata_in[DOG_ENA_BIT]; // RULE2
                end
                default: begin
                    // writes to other offsets belong to the timer part
                end
            endcase
        end
        // automatic repeat timer
        if (state_reg.auto_armed && state_reg.auto_mode) begin
            if (state_reg.tick >= period - TICK_W'(1)) begin
                state_next.tick = '0;
                state_next.start = 1'b1; // RULE4
                state_next.conv  = CONV_BUSY;
            end else begin
                state_next.tick = state_reg.tick + TICK_W'(1);
            end
        end
        // converter completion and comparison; completion's request set wins over a same-cycle clear
        if (state_reg.conv == CONV_BUSY && adc_done_in && !state_reg.start) begin
            // a start landing in the same cycle keeps the sequencer busy,
            // otherwise the new conversion's result would be dropped
            state_next.conv   = state_next.start ? CONV_BUSY : CONV_DONE;
            state_next.result = adc_result_in;
            state_next.over_limit_flag = (adc_result_in >= state_reg.limit); // RULE13 RULE6
            if (adc_result_in >= state_reg.limit) begin
                state_next.irq = 1'b1; // RULE5 set beats clear
            end
        end
        // outputs blocked until released by software
        state_next.ttl   = state_reg.dog_released && dog_expired_in; // RULE2 RULE7
        state_next.oc    = state_reg.dog_released && dog_expired_in; // RULE7
        state_next.relay = state_reg.dog_released && dog_expired_in; // RULE7
    end

    // state register; no autonomous setup of timers at reset
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_reg <= '0; // RULE1
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from flip-flops
    assign adc_start_out           = state_reg.start;
    assign io_rdata_out            = state_reg.rdata;
    assign io_claim_out            = state_reg.claim;
    assign over_limit_irq_line_out = state_reg.irq;
    assign dog_ttl_out             = state_reg.ttl;
    assign dog_oc_oe_out           = state_reg.oc;
    assign dog_relay_out           = state_reg.relay;

endmodule : watchdog_temp_monitor_port

// ===== wdt_mon_pkg.sv
// package of constants for the watchdog and temperature monitor port
package wdt_mon_pkg;
    // i/o window: eight byte addresses, base in 8-byte steps below 0800h
    localparam int          WIN_BYTES      = 8;
    localparam int          OFS_W          = 3;
    localparam int          BASE_SW_W      = 8;
    // register offsets inside the window
    localparam logic [2:0]  OFS_CONV_START = 3'h0; // write: start conversion
    localparam logic [2:0]  OFS_ADC_DATA   = 3'h1; // read: result
    localparam logic [2:0]  OFS_ADC_STATUS = 3'h2; // read: status
    localparam logic [2:0]  OFS_LIMIT      = 3'h3; // write/read: limit
    localparam logic [2:0]  OFS_MODE       = 3'h6; // write: conversion mode
    localparam logic [2:0]  OFS_DOG        = 3'h7; // write: watchdog trigger/release
    // status bit positions
    localparam int          ST_EOC_BIT     = 7;
    localparam int          ST_DOG_BIT     = 6;
    localparam int          ST_OVER_BIT    = 5;
    // mode and dog data bits
    localparam int          MODE_AUTO_BIT  = 0;
    localparam int          DOG_ENA_BIT    = 0;
    // timing
    localparam longint      CLK_HZ         = 250_000_000;
    localparam int          INTERVAL_S_SHORT = 1;
    localparam int          INTERVAL_S_LONG  = 4;
    localparam longint      TICKS_SHORT    = CLK_HZ * INTERVAL_S_SHORT;
    localparam longint      TICKS_LONG     = CLK_HZ * INTERVAL_S_LONG;
    localparam int          TICK_W         = 32;
    // state encoding of the converter sequencer
    typedef enum logic [1:0] {
        CONV_IDLE = 2'b00,
        CONV_BUSY = 2'b01,
        CONV_DONE = 2'b10
    } conv_state_e;
    localparam logic [7:0]  BYTE_ZERO      = 8'h00;
endpackage : wdt_mon_pkg

// ===== wdt_mon_monitor.sv
// concurrent checks on the host window and watchdog outputs
module wdt_mon_monitor
    import wdt_mon_pkg::*;
(
    input  wire logic                 clk_in,
    input  wire logic                 resetn_in,
    input  wire logic [15:0]          io_addr_in,
    input  wire logic                 io_rd_in,
    input  wire logic                 io_wr_in,
    input  wire logic                 mem_cycle_in,
    input  wire logic [BASE_SW_W-1:0] base_sw_in,
    input  wire logic                 dog_expired_in,
    input  wire logic                 adc_start_out,
    input  wire logic [7:0]           io_rdata_out,
    input  wire logic                 io_claim_out,
    input  wire logic                 dog_ttl_out,
    input  wire logic                 dog_oc_oe_out,
    input  wire logic                 dog_relay_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    // decode worked out here on all sixteen lines, not copied from the design
    wire logic hit = (io_rd_in | io_wr_in) & ~mem_cycle_in & (io_addr_in[15:3] == {5'h00, base_sw_in});
    a_claim_on_hit: assert property (hit |=> io_claim_out) else $error("window access not claimed");
    a_miss_ignored: assert property (!hit |=> !io_claim_out && io_rdata_out == 8'h00)
        else $error("access outside the window answered");
    a_mem_ignored: assert property (mem_cycle_in |=> !io_claim_out) else $error("memory cycle claimed");
    a_write_quiet: assert property (hit && io_wr_in && !io_rd_in |=> io_rdata_out == 8'h00)
        else $error("read data driven on a write");
    a_start_on_write: assert property (hit && io_wr_in && io_addr_in[2:0] == OFS_CONV_START |=> adc_start_out)
        else $error("start write gave no start pulse");
    a_start_single: assert property (adc_start_out |=> !adc_start_out) else $error("start pulse too long");
    a_dog_together: assert property (dog_ttl_out == dog_oc_oe_out && dog_ttl_out == dog_relay_out)
        else $error("timeout outputs disagree");
    a_dog_cause: assert property (dog_ttl_out |-> $past(dog_expired_in)) else $error("timeout without expiry");
endmodule : wdt_mon_monitor

bind watchdog_temp_monitor_port wdt_mon_monitor i_wdt_mon_monitor (.*);

// ===== wdt_adc_model.sv
// converter model: answers a start pulse with a result after a delay
module wdt_adc_model #(
    parameter int DELAY = 10 // conversion time in clocks
) (
    input  wire logic       clk_in,
    input  wire logic       start_in,   // start pulse from the port
    input  wire logic [7:0] value_in,   // temperature set by the bench
    output logic            done_out,   // one-cycle end pulse
    output logic [7:0]      result_out  // valid only with done_out
);
    int         cnt  = 0;     // clocks left in the conversion
    logic [7:0] last = 8'h00; // last result handed over
    // released data lines show the inverse, so stale values never pass
    always @(posedge clk_in) begin
        done_out <= (cnt == 1);
        result_out <= (cnt == 1) ? value_in : ~last;
        if (cnt == 1) last <= value_in;
        cnt <= start_in ? DELAY : (cnt > 0 ? cnt - 1 : 0);
    end
endmodule : wdt_adc_model

// ===== watchdog_temp_monitor_port_bench.sv
// self-checking bench for the watchdog and temperature monitor port
module watchdog_temp_monitor_port_bench import wdt_mon_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_in = 0, resetn_in = 0, io_rd_in = 0, io_wr_in = 0, mem_cycle_in = 0, c;
    logic long_interval_in = 0, dog_expired_in = 1, adc_done_in, adc_start_out, io_claim_out;
    logic over_limit_irq_line_out, dog_ttl_out, dog_oc_oe_out, dog_relay_out;
    logic [15:0] io_addr_in = 16'h0000, B = 16'h07f8; // top base, switches all on
    logic [7:0] io_wdata_in = 8'h00, base_sw_in = 8'hff, temp = 8'h00, adc_result_in, io_rdata_out, q;
    logic [16:0] miss [4] = '{17'h00800, 17'h087f8, 17'h107fb, 17'h007f7}; // bit16: memory cycle
    int err_count = 0, tests_run = 0;
    watchdog_temp_monitor_port i_watchdog_temp_monitor_port (.*);
    wdt_adc_model i_wdt_adc_model (.clk_in(clk_in), .start_in(adc_start_out), .value_in(temp),
        .done_out(adc_done_in), .result_out(adc_result_in));
    initial forever #2 clk_in = ~clk_in;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one bus cycle: strobe for one clock, answer read a clock later
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d, input logic m);
        @(posedge clk_in);
        {io_wr_in, io_rd_in, io_addr_in, io_wdata_in, mem_cycle_in} <= {w, !w, a, d, m};
        @(posedge clk_in);
        {io_wr_in, io_rd_in, mem_cycle_in} <= 3'b000;
        #1 c = io_claim_out;
        q = io_rdata_out;
    endtask : acc
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run
    initial begin
        #4000 err_count++;
        complete_run();
    end
    initial begin
        repeat (4) @(posedge clk_in);
        resetn_in <= 1;
        acc(1, B + 3, 8'h80, 0);
        acc(0, B + 3, 0, 0);
        chk(q, 8'h80);
        #20 chk(dog_ttl_out, 0);
        acc(1, B + 7, 8'h01, 0);
        #8 chk({dog_ttl_out, dog_oc_oe_out, dog_relay_out}, 3'b111);
        $display("test watchdog release done");
        // result equal to the limit, then one below it
        for (int i = 0; i < 2; i++) begin
            temp = 8'h80 - i;
            acc(1, B, 8'h00, 0);
            chk(c, 1);
            acc(0, B + 2, 0, 0);
            chk(q[7], 1);
            repeat (15) @(posedge clk_in);
            #1 chk(over_limit_irq_line_out, i == 0);
            acc(0, B + 2, 0, 0);
            chk(q[7:5], {2'b00, i == 0});
            acc(0, B + 1, 0, 0);
            chk(q, 8'h80 - i);
            chk(over_limit_irq_line_out, 0);
        end
        // a mode write clears a pending over-limit request
        temp = 8'h90;
        acc(1, B, 8'h00, 0);
        repeat (15) @(posedge clk_in);
        #1 chk(over_limit_irq_line_out, 1);
        acc(1, B + 6, 8'h00, 0);
        chk(over_limit_irq_line_out, 0);
        $display("test conversions done");
        @(posedge clk_in);
        dog_expired_in <= 0;
        acc(0, B + 4, 0, 0);
        chk(c, 1);
        foreach (miss[k]) begin
            acc(0, miss[k][15:0], 0, miss[k][16]);
            chk(c, 0);
            chk(q, 0);
        end
        chk(dog_ttl_out, 0);
        $display("test window decode done");
        complete_run();
    end
endmodule : watchdog_temp_monitor_port_bench
